// file: hw/vfdks_defs.vh
// constants for the display timing, segment output and key scan block
`ifndef VFDKS_DEFS_VH
`define VFDKS_DEFS_VH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define VFDKS_IDX_MEM_LO   12'h1A0
`define VFDKS_IDX_MEM_HI   12'h1FF
`define VFDKS_IDX_KS0      12'h1FC
`define VFDKS_IDX_KS1      12'h1FE
`define VFDKS_IDX_KS2      12'h1BE
`define VFDKS_IDX_MODE     12'hF88
`define VFDKS_IDX_DIGIT_COUNT_REG     12'hF8A
`define VFDKS_IDX_DIMMER_CYCLE_SELECT     12'hF8C
`define VFDKS_IDX_HIGH_SEGMENT_STATIC_SELECT    12'hFD4
`define VFDKS_IDX_LOW_SEGMENT_STATIC_SELECT    12'hFD6

// ************************************************************
// display memory layout, as array indices
// ************************************************************
`define VFDKS_MEM_DEPTH    96
`define VFDKS_LOW_BASE     7'h20
`define VFDKS_KS0_ARR      7'h5C
`define VFDKS_KS2_ARR      7'h1E

// ************************************************************
// reset values and fields
// ************************************************************
`define VFDKS_RST_MODE     4'h0
`define VFDKS_RST_DIGIT_COUNT_REG     4'h8
`define VFDKS_RST_DIMMER_CYCLE_SELECT     4'h0
`define VFDKS_RST_LOW_SEGMENT_STATIC_SELECT    4'h0
`define VFDKS_RST_HIGH_SEGMENT_STATIC_SELECT    2'h0
`define VFDKS_KSF_BIT      3
`define VFDKS_EN_BIT       3
`define VFDKS_SEG_BASE     5'h09
`define VFDKS_HIGH_SEGMENT_STATIC_SELECT_LSB    4

// ************************************************************
// timing counts in main clock periods
// ************************************************************
`define VFDKS_SLOT_SHORT   12'h400
`define VFDKS_SLOT_LONG    12'h800
`define VFDKS_CUT_SHIFT_S  6
`define VFDKS_CUT_SHIFT_L  7

`endif

// file: hw/vfdks_top.v
// display timing, segment output selection and key scan for a tube driver
//
// Operation
// R1: cycle bit 1 gives 2048-clock slot
// R2: cycle bit 0 gives 1024-clock slot
// R3: upper dimmer bits cut digit pulse width
// R4: reset clears both static select registers
// R5: low static zero: pins 0-15 dynamic
// R6: low static ones: pins 0-15 from latches
// R7: software sets each group's bits uniformly
// R8: high static zero: pins 16-23 dynamic
// R9: high static ones: pins 16-23 from latches
// R10: display data fetched from 1A0H-1FFH memory
// R11: 1-,4-,8-bit access, 8-bit even only
// R12: key scan words alias display memory
// R13: key scan slot drives key scan words
// R14: key scan writes show on segments immediately
// R15: key scan words byte wide, nibble low
// R16: key scan flag reads slot, ignores writes
// R17: key scan event goes to interrupt logic
// R18: mode bit 3 enables, low bits segments
// R19: N+1 digits, period N+2 slots
// R20: one key scan slot after last digit
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`include "vfdks_defs.vh"

module vfdks_top
#(
    parameter ADDR_W = 14
)
(
    // clock and reset
    input  wire              clk_i,
    input  wire              reset_n_i,
    // avalon-mm slave
    input  wire [ADDR_W-1:0] avs_address_i,
    input  wire              avs_read_i,
    input  wire              avs_write_i,
    input  wire [31:0]       avs_writedata_i,
    input  wire [3:0]        avs_byteenable_i,
    output reg  [31:0]       avs_readdata_o,
    output wire              avs_waitrequest_o,
    // static port output latches
    input  wire [15:0]       port_latch_lo_i,
    input  wire [7:0]        port_latch_hi_i,
    // tube drive
    output reg  [23:0]       seg_o,
    output reg  [15:0]       digit_o,
    // key scan
    output reg               key_scan_interrupt_o,
    output wire              key_scan_status_flag_o
);

    // ************************************************************
    // state encoding
    // ************************************************************
    localparam [2:0] ST_OFF   = 3'h1;
    localparam [2:0] ST_DIGIT = 3'h2;
    localparam [2:0] ST_SCAN  = 3'h4;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function mem_hit;
        input [11:0] idx;
        begin
            mem_hit = (idx >= `VFDKS_IDX_MEM_LO) &&
                      (idx <= `VFDKS_IDX_MEM_HI);
        end
    endfunction

    // upper nibble of a key scan word takes byte access only
    function ks_upper;
        input [11:0] idx;
        begin
            ks_upper = (idx == `VFDKS_IDX_KS0 + 12'h001) ||
                       (idx == `VFDKS_IDX_KS1 + 12'h001) ||
                       (idx == `VFDKS_IDX_KS2 + 12'h001);
        end
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    reg  [3:0]  mem [0:`VFDKS_MEM_DEPTH-1];
    reg  [3:0]  display_mode_reg;
    reg  [3:0]  digit_count_reg;
    reg  [3:0]  dimmer_cycle_select;
    reg  [3:0]  low_segment_static_select;
    reg  [1:0]  high_segment_static_select;
    reg         ack;
    reg  [2:0]  state;
    reg  [11:0] slot_cnt;
    reg  [4:0]  digit_idx;

    wire        req = avs_read_i | avs_write_i;
    wire [11:0] idx = avs_address_i[13:2];
    wire        aligned = (avs_address_i[1:0] == 2'h0);
    wire        wide = avs_byteenable_i[1];
    wire [11:0] arr_full = idx - `VFDKS_IDX_MEM_LO;
    wire [6:0]  arr = arr_full[6:0];
    wire [6:0]  arr_p1 = arr + 7'h01;
    wire        do_wr = avs_write_i & ack & aligned;
    // load in the wait cycle so data stands when waitrequest drops
    wire        do_rd = avs_read_i & ~ack;

    // one wait cycle: request taken on the edge where ack is high
    assign avs_waitrequest_o = req & ~ack;

    // legal memory access: byte at even index, nibble except ks upper
    wire mem_ok = aligned & mem_hit(idx) &
                  (wide ? ~idx[0] : ~ks_upper(idx));  // R11 R15

    // ************************************************************
    // bus handshake and control registers
    // ************************************************************
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack                        <= 1'b0;
            display_mode_reg           <= `VFDKS_RST_MODE;
            digit_count_reg            <= `VFDKS_RST_DIGIT_COUNT_REG;
            dimmer_cycle_select        <= `VFDKS_RST_DIMMER_CYCLE_SELECT;
            low_segment_static_select  <= `VFDKS_RST_LOW_SEGMENT_STATIC_SELECT;  // R4
            high_segment_static_select <= `VFDKS_RST_HIGH_SEGMENT_STATIC_SELECT;  // R4
        end
        else
        begin
            ack <= req & ~ack;
            if (do_wr && avs_byteenable_i[0])
            begin
                case (idx)
                    `VFDKS_IDX_MODE:
                        display_mode_reg <= avs_writedata_i[3:0];
                    // flag bit shares this index and is never written
                    `VFDKS_IDX_DIGIT_COUNT_REG:
                        digit_count_reg <= {1'b1, avs_writedata_i[2:0]};
                    `VFDKS_IDX_DIMMER_CYCLE_SELECT:
                        dimmer_cycle_select <= avs_writedata_i[3:0];
                    `VFDKS_IDX_LOW_SEGMENT_STATIC_SELECT:
                        low_segment_static_select <= avs_writedata_i[3:0];
                    `VFDKS_IDX_HIGH_SEGMENT_STATIC_SELECT:
                        high_segment_static_select <=
                            avs_writedata_i[5:`VFDKS_HIGH_SEGMENT_STATIC_SELECT_LSB];
                    default:
                        ;
                endcase
            end
        end
    end

    // ************************************************************
    // display data memory, shared by cpu and display fetch
    // ************************************************************
    // plain data memory: no reset, software initialises it
    always @(posedge clk_i)
    begin
        if (do_wr && mem_ok && avs_byteenable_i[0])  // R10 R12
        begin
            mem[arr] <= avs_writedata_i[3:0];
            if (wide)
                mem[arr_p1] <= avs_writedata_i[7:4];  // R11
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    reg [31:0] next_rdata;

    always @*
    begin
        next_rdata = 32'h0000_0000;
        if (aligned)
        begin
            if (mem_ok)
            begin
                next_rdata[3:0] = mem[arr];
                if (wide)
                    next_rdata[7:4] = mem[arr_p1];
            end
            else
            begin
                case (idx)
                    `VFDKS_IDX_MODE:
                        next_rdata[3:0] = display_mode_reg;
                    `VFDKS_IDX_DIGIT_COUNT_REG:
                        next_rdata[3:0] = {key_scan_status_flag_o,
                                           digit_count_reg[2:0]};  // R16
                    `VFDKS_IDX_DIMMER_CYCLE_SELECT:
                        next_rdata[3:0] = dimmer_cycle_select;
                    `VFDKS_IDX_LOW_SEGMENT_STATIC_SELECT:
                        next_rdata[3:0] = low_segment_static_select;
                    `VFDKS_IDX_HIGH_SEGMENT_STATIC_SELECT:
                        next_rdata[5:4] = high_segment_static_select;
                    default:
                        next_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            avs_readdata_o <= 32'h0000_0000;
        else if (do_rd)
            avs_readdata_o <= next_rdata;
    end

    // ************************************************************
    // slot timing
    // ************************************************************
    wire        enabled  = display_mode_reg[`VFDKS_EN_BIT];  // R18
    wire        long_sl  = dimmer_cycle_select[0];
    wire [11:0] slot_len = long_sl ? `VFDKS_SLOT_LONG        // R1
                                   : `VFDKS_SLOT_SHORT;      // R2
    wire        slot_end = (slot_cnt == slot_len - 12'h001);
    wire        last_dig = (digit_idx == {1'b0, digit_count_reg});

    reg [2:0]  next_state;
    reg [4:0]  next_digit_idx;

    always @*
    begin
        next_state     = state;
        next_digit_idx = digit_idx;
        case (state)
            ST_OFF:
            begin
                next_digit_idx = 5'h00;
                if (enabled)
                    next_state = ST_DIGIT;
            end
            ST_DIGIT:
            begin
                if (!enabled)
                    next_state = ST_OFF;
                else if (slot_end && last_dig)
                    next_state = ST_SCAN;                 // R19 R20
                else if (slot_end)
                    next_digit_idx = digit_idx + 5'h01;  // R19
            end
            ST_SCAN:
            begin
                if (!enabled)
                    next_state = ST_OFF;
                else if (slot_end)
                begin
                    next_state     = ST_DIGIT;             // R20
                    next_digit_idx = 5'h00;
                end
            end
            default:
                next_state = ST_OFF;
        endcase
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state                <= ST_OFF;
            slot_cnt             <= 12'h000;
            digit_idx            <= 5'h00;
            key_scan_interrupt_o <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            digit_idx <= next_digit_idx;
            if (state == ST_OFF || slot_end || next_state == ST_OFF)
                slot_cnt <= 12'h000;
            else
                slot_cnt <= slot_cnt + 12'h001;
            // one pulse as the key scan slot opens
            key_scan_interrupt_o <= (state == ST_DIGIT) &&
                                    (next_state == ST_SCAN);  // R17
        end
    end

    assign key_scan_status_flag_o = (state == ST_SCAN);  // R16

    // ************************************************************
    // dimmer cut
    // ************************************************************
    reg [3:0] cut_frac;

    always @*
    begin
        case (dimmer_cycle_select[3:1])  // R3
            3'h0:    cut_frac = 4'h1;
            default: cut_frac = {dimmer_cycle_select[3:1], 1'b0};
        endcase
    end

    // blanking sits at the start of each slot to hide ghosting
    wire [11:0] cut_len = long_sl ?
        ({8'h00, cut_frac} << `VFDKS_CUT_SHIFT_L) :
        ({8'h00, cut_frac} << `VFDKS_CUT_SHIFT_S);
    wire digit_on = (state == ST_DIGIT) && (slot_cnt >= cut_len);  // R3

    // ************************************************************
    // segment mask from mode count
    // ************************************************************
    wire [4:0]  seg_cnt = `VFDKS_SEG_BASE + {2'h0, display_mode_reg[2:0]};
    wire [15:0] seg_mask;

    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_mask
            assign seg_mask[g] = (g < seg_cnt);  // R18
        end
    endgenerate

    // ************************************************************
    // segment and digit output
    // ************************************************************
    wire       lo_static = low_segment_static_select[3];
    wire       hi_static = high_segment_static_select[1];
    wire [6:0] lo_base = `VFDKS_LOW_BASE + {digit_idx[3:0], 2'h0};
    wire [6:0] hi_base = {2'h0, digit_idx[3:0], 1'b0};

    reg [15:0] lo_data;
    reg [7:0]  hi_data;
    reg [23:0] next_seg;
    reg [15:0] next_digit;

    // read live every cycle so key scan writes reach the pins at once
    always @*
    begin
        lo_data = 16'h0000;
        hi_data = 8'h00;
        if (state == ST_SCAN)
        begin
            lo_data = {mem[`VFDKS_KS0_ARR + 7'h03],
                       mem[`VFDKS_KS0_ARR + 7'h02],
                       mem[`VFDKS_KS0_ARR + 7'h01],
                       mem[`VFDKS_KS0_ARR]};           // R13 R14
            hi_data = {mem[`VFDKS_KS2_ARR + 7'h01],
                       mem[`VFDKS_KS2_ARR]};           // R13 R14
        end
        else if (state == ST_DIGIT)
        begin
            lo_data = {mem[lo_base + 7'h03], mem[lo_base + 7'h02],
                       mem[lo_base + 7'h01], mem[lo_base]};  // R10
            hi_data = {mem[hi_base + 7'h01], mem[hi_base]};  // R8
        end
    end

    always @*
    begin
        next_seg   = 24'h00_0000;
        next_digit = 16'h0000;
        // static groups ignore the enable bit
        if (lo_static)
            next_seg[15:0] = port_latch_lo_i;        // R6
        else
            next_seg[15:0] = lo_data & seg_mask;     // R5
        if (hi_static)
            next_seg[23:16] = port_latch_hi_i;       // R9
        else
            next_seg[23:16] = hi_data;               // R8
        if (digit_on)
            next_digit[digit_idx[3:0]] = 1'b1;       // R19 R20
    end

    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            seg_o   <= 24'h00_0000;
            digit_o <= 16'h0000;
        end
        else
        begin
            seg_o   <= next_seg;
            digit_o <= next_digit;
        end
    end

endmodule

// file: tb/vfdks_props.sv
// concurrent checks on the tube timing and key scan block ports
`timescale 1ns/100ps
module vfdks_props
#(
    parameter ADDR_W = 14
)
(
    // clock and reset
    input wire              clk_i,
    input wire              reset_n_i,
    // register bus
    input wire [ADDR_W-1:0] avs_address_i,
    input wire              avs_read_i,
    input wire              avs_write_i,
    input wire [31:0]       avs_readdata_o,
    input wire              avs_waitrequest_o,
    // tube and key scan
    input wire [15:0]       digit_o,
    input wire              key_scan_interrupt_o,
    input wire              key_scan_status_flag_o
);
// ************************************************************
// helpers and properties
// ************************************************************
    logic [11:0] run;
    wire         rd_ok = avs_read_i && !avs_waitrequest_o;
    wire  [11:0] idx   = avs_address_i[13:2];
    wire         key_scan_status_flag   = key_scan_status_flag_o;
    // run length of the scan slot, too long for a repetition
    always @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
            run <= 12'h000;
        else
            run <= key_scan_status_flag ? run + 12'h001 : 12'h000;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_one_wait;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    sequence s_pulse;
        key_scan_interrupt_o ##1 !key_scan_interrupt_o;
    endsequence
    a_one_wait: assert property ($rose(avs_read_i || avs_write_i)
        |-> s_one_wait) else $error("bus wait not one cycle");
    a_unmapped_zero: assert property (rd_ok && idx < 12'h1A0
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not 0");
    a_flag_read: assert property (rd_ok && idx == 12'hF8A && $stable(key_scan_status_flag)
        |-> avs_readdata_o[3] == key_scan_status_flag) else $error("flag read wrong");
    a_stat_rsvd: assert property (rd_ok && idx == 12'hFD6
        |-> avs_readdata_o[31:4] == 28'h0) else $error("static high bits");
    a_int_once: assert property (key_scan_interrupt_o |-> s_pulse)
        else $error("interrupt longer than one cycle");
    a_int_cause: assert property (key_scan_interrupt_o |-> key_scan_status_flag)
        else $error("interrupt outside scan slot");
    a_int_follow: assert property ($rose(key_scan_status_flag)
        |-> ##[0:1] key_scan_interrupt_o) else $error("no scan interrupt");
    a_scan_dark: assert property (key_scan_status_flag && $past(key_scan_status_flag)
        |-> digit_o == 16'h0) else $error("digit lit in scan slot");
    a_digit_hot: assert property ($onehot0(digit_o))
        else $error("two digits lit");
    a_scan_len: assert property ($fell(key_scan_status_flag)
        |-> run == 12'h400 || run == 12'h800) else $error("slot length");
endmodule

// file: tb/vfdks_tube.sv
// tube model: digits lit per period and digit 0 pulse width
`timescale 1ns/100ps
module vfdks_tube
(
    // clock and reset
    input  wire         clk_i,
    input  wire         reset_n_i,
    // electrodes
    input  wire  [23:0] seg_i,
    input  wire  [15:0] digit_i,
    // observations
    output logic [4:0]  digits_seen_o,
    output logic [11:0] dig0_width_o
);
// ************************************************************
// electrode watch
// ************************************************************
    logic [15:0] prev;
    logic [4:0]  cnt;
    logic [11:0] w;
    // segments sink through pull-downs, nothing to model there
    always @(posedge clk_i or negedge reset_n_i)
        if (!reset_n_i)
        begin
            prev <= 16'h0000;
            cnt <= 5'h00;
            w <= 12'h000;
            digits_seen_o <= 5'h00;
            dig0_width_o <= 12'h000;
        end
        else
        begin
            prev <= digit_i;
            if (digit_i[0] && !prev[0])
            begin
                digits_seen_o <= cnt;
                cnt <= 5'h01;
            end
            else if ((digit_i & ~prev) != 16'h0000)
                cnt <= cnt + 5'h01;
            if (digit_i[0])
                w <= w + 12'h001;
            else if (prev[0])
            begin
                dig0_width_o <= w;
                w <= 12'h000;
            end
        end
endmodule

// file: tb/vfd_segment_output_keyscan_tb.sv
// self-checking bench for the tube timing and key scan block
`timescale 1ns/100ps
`define CHK(a, b) \
    begin \
        samples_checked++; \
        if ((a) !== (b)) \
        begin \
            n_fail++; \
            $display("mismatch at %0t: compare failed", $time); \
        end \
    end
module vfd_segment_output_keyscan_tb;
// ************************************************************
// signals and instances
// ************************************************************
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [13:0] addr = 14'h0000;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  ben = 4'h0;
    logic [15:0] lat_lo = 16'hC3A5;
    logic [7:0]  lat_hi = 8'h5A;
    wire  [31:0] rdata;
    wire         waitreq;
    wire  [23:0] seg;
    wire  [15:0] dig;
    wire         irq;
    wire         key_scan_status_flag;
    wire  [4:0]  seen;
    wire  [11:0] w0;
    logic [31:0] rdv;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          n = 0;
    vfdks_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en),
        .avs_writedata_i(wdata), .avs_byteenable_i(ben),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .port_latch_lo_i(lat_lo), .port_latch_hi_i(lat_hi), .seg_o(seg),
        .digit_o(dig), .key_scan_interrupt_o(irq),
        .key_scan_status_flag_o(key_scan_status_flag));
    vfdks_tube u_tube (.clk_i(clk_i), .reset_n_i(reset_n_i), .seg_i(seg),
        .digit_i(dig), .digits_seen_o(seen), .dig0_width_o(w0));
    initial
        forever #12.5 clk_i = ~clk_i;
// ************************************************************
// tasks
// ************************************************************
    task automatic bus(input logic w, input logic [11:0] idx,
                       input logic [3:0] b, input logic [7:0] d);
        logic ws;
        @(posedge clk_i);
        addr <= {idx, 2'b00};
        rd_en <= !w;
        wr_en <= w;
        wdata <= {24'h000000, d};
        ben <= b;
        // waitrequest only moves on rising edges: look at it mid-cycle
        do
        begin
            @(negedge clk_i);
            ws = waitreq;
            @(posedge clk_i);
        end
        while (ws !== 1'b0);
        rdv = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task run_to(input logic v);
        while (key_scan_status_flag !== v)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask
    task t_reset;
        bus(0, 12'hFD6, 4'h3, 8'h00);
        `CHK(rdv, 32'h0)
        bus(0, 12'hFD4, 4'h3, 8'h00);
        `CHK(rdv, 32'h0)
    endtask
    task t_static;
        bus(1, 12'hFD6, 4'h3, 8'h0F);
        bus(1, 12'hFD4, 4'h3, 8'h30);
        repeat (3) @(posedge clk_i);
        `CHK(seg, 24'h5AC3A5)
        bus(1, 12'hFD6, 4'h3, 8'h00);
        bus(1, 12'hFD4, 4'h3, 8'h00);
        repeat (3) @(posedge clk_i);
        `CHK(seg, 24'h000000)
    endtask
    task t_mem;
        bus(1, 12'h1C0, 4'h3, 8'h5A);
        bus(1, 12'h1C2, 4'h3, 8'h3C);
        bus(1, 12'h1C3, 4'h3, 8'hFF);
        bus(1, 12'h1A0, 4'h3, 8'h96);
        bus(1, 12'h1FC, 4'h3, 8'hA5);
        bus(1, 12'h1FE, 4'h3, 8'h81);
        bus(1, 12'h1BE, 4'h3, 8'h69);
        bus(0, 12'h1C1, 4'h1, 8'h00);
        `CHK(rdv[3:0], 4'h5)
        bus(0, 12'h1C2, 4'h3, 8'h00);
        `CHK(rdv[7:0], 8'h3C)
        bus(0, 12'h010, 4'h1, 8'h00);
        `CHK(rdv, 32'h0)
    endtask
    task t_dyn;
        bus(1, 12'hF8C, 4'h1, 8'h00);
        bus(1, 12'hF88, 4'h1, 8'h0F);
        while (dig[0] !== 1'b1)
            @(negedge clk_i);
        @(negedge clk_i);
        `CHK(seg, 24'h963C5A)
        run_to(1);
        @(negedge clk_i);
        `CHK(seg, 24'h6981A5)
        `CHK(dig, 16'h0000)
        bus(1, 12'hF8A, 4'h1, 8'h00);
        bus(0, 12'hF8A, 4'h1, 8'h00);
        `CHK(rdv[3], 1'b1)
        bus(1, 12'h1FC, 4'h3, 8'h3C);
        repeat (3) @(posedge clk_i);
        `CHK(seg[7:0], 8'h3C)
        bus(1, 12'h1FD, 4'h1, 8'h0F);
        bus(0, 12'h1FC, 4'h3, 8'h00);
        `CHK(rdv[7:0], 8'h3C)
        run_to(0);
        run_to(1);
        n = 0;
        run_to(0);
        run_to(1);
        `CHK(n, 32'h00002800)
        `CHK(seen, 5'h09)
        `CHK(w0, 12'h3C0)
    endtask
    task t_long;
        // nine segments now: the scan word's bit 8 survives the mask
        bus(1, 12'hF88, 4'h1, 8'h08);
        bus(1, 12'hF8C, 4'h1, 8'h0F);
        run_to(0);
        run_to(1);
        @(negedge clk_i);
        `CHK(seg, 24'h69013C)
        n = 1;
        run_to(0);
        run_to(1);
        `CHK(n, 32'h00005000)
        `CHK(w0, 12'h100)
    endtask
    task close_out;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
// ************************************************************
// sequence and watchdog
// ************************************************************
    initial
    begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset;
        t_static;
        t_mem;
        t_dyn;
        t_long;
        close_out;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 32'h00015F90)
        begin
            n_fail++;
            close_out;
        end
    end
endmodule
bind vfdks_top vfdks_props #(.ADDR_W(ADDR_W)) u_props (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .digit_o(digit_o), .key_scan_interrupt_o(key_scan_interrupt_o),
    .key_scan_status_flag_o(key_scan_status_flag_o));
